/* cit_pkg.sv */
package cit_pkg;

  // Counter and bus-count widths used by the timing core.
  localparam int CNT_W = 8;
  localparam int BUS_W = 6;

  // Fixed step lengths and bus-cycle allowances, in clocks.
  localparam logic [CNT_W-1:0] SAVE_CLOCKS    = 8'h03;
  localparam logic [CNT_W-1:0] LONG_EXTRA     = 8'h02;
  localparam logic [3:0]       BUS_NOMINAL    = 4'h2;
  localparam logic [3:0]       BUS_TOLERANT   = 4'h4;
  localparam logic [3:0]       WAIT_MAX       = 4'hF;

  // The tabulated figures hold with the external bus in this mode.
  localparam int EXT_BUS_BITS = 16;

  // Operation classes that the timing engine knows.
  typedef enum logic [4:0] {
    OP_ALU_REG, OP_ALU_MEM, OP_IMM_REG, OP_IMM_MEM, OP_QUICK_REG, OP_QUICK_MEM,
    OP_WORD_MUL, OP_WORD_DIV, OP_LONG_MUL, OP_LONG_DIV, OP_TBL_MEM,
    OP_DEC_REG, OP_DEC_MEM, OP_EXT_REG, OP_EXT_MEM, OP_POSTINCREMENT_MEMORY_COMPARE,
    OP_ALT_RD, OP_ALT_WR, OP_MULTI_RD, OP_MULTI_WR
  } cit_op_t;

  // One instruction handed to the engine.
  typedef struct packed {
    cit_op_t    op;
    logic       longSize;
    logic       signedOp;
    logic       srcIsDreg;
    logic [5:0] eaClocks;
    logic [4:0] regCount;
  } cit_req_t;

  // Base timing of one operation class.
  typedef struct packed {
    logic [3:0] head;
    logic [3:0] tail;
    logic [7:0] cycles;
    logic [2:0] reads;
    logic [1:0] prefetch;
    logic [1:0] writes;
    logic       sizeScaled;
    logic       hasSave;
    logic       addsEa;
    logic       tolerant;
    logic       perReg;
  } cit_entry_t;

  // Timing reported for the instruction in progress.
  typedef struct packed {
    logic [7:0] totalClocks;
    logic [3:0] head;
    logic [4:0] tail;
    logic [5:0] busCycles;
  } cit_result_t;

  // Builds one timing entry from its figures and flags.
  function automatic cit_entry_t citMk(input int h, input int t, input int c, input int r, input int p,
                                       input int w, input logic x, input logic sv, input logic ea,
                                       input logic tol, input logic pr);
    cit_entry_t e;
    e.head       = 4'(h);
    e.tail       = 4'(t);
    e.cycles     = 8'(c);
    e.reads      = 3'(r);
    e.prefetch   = 2'(p);
    e.writes     = 2'(w);
    e.sizeScaled = x;
    e.hasSave    = sv;
    e.addsEa     = ea;
    e.tolerant   = tol;
    e.perReg     = pr;
    return e;
  endfunction : citMk

  // Head, tail, cycles, reads, prefetches, writes, then the flag bits.
  localparam cit_entry_t E_ALU_REG    = citMk(0, 0, 2, 0, 1, 0, 1'h0, 1'h0, 1'h1, 1'h0, 1'h0);
  localparam cit_entry_t E_ALU_MEM    = citMk(0, 3, 5, 0, 1, 1, 1'h1, 1'h0, 1'h1, 1'h0, 1'h0);
  localparam cit_entry_t E_IMM_REG    = citMk(0, 0, 2, 0, 1, 0, 1'h0, 1'h0, 1'h1, 1'h0, 1'h0);
  localparam cit_entry_t E_IMM_MEM    = citMk(0, 3, 5, 0, 1, 1, 1'h1, 1'h0, 1'h1, 1'h0, 1'h0);
  localparam cit_entry_t E_QUICK_REG  = citMk(0, 0, 2, 0, 1, 0, 1'h0, 1'h0, 1'h0, 1'h0, 1'h0);
  localparam cit_entry_t E_QUICK_MEM  = citMk(0, 3, 5, 0, 1, 1, 1'h1, 1'h0, 1'h0, 1'h0, 1'h0);
  localparam cit_entry_t E_WORD_MUL   = citMk(0, 0, 26, 0, 1, 0, 1'h0, 1'h0, 1'h1, 1'h0, 1'h0);
  localparam cit_entry_t E_WORD_UDIV  = citMk(0, 0, 32, 0, 1, 0, 1'h0, 1'h0, 1'h1, 1'h0, 1'h0);
  localparam cit_entry_t E_WORD_SDIV  = citMk(0, 0, 42, 0, 1, 0, 1'h0, 1'h0, 1'h1, 1'h0, 1'h0);
  localparam cit_entry_t E_LONG_MUL   = citMk(2, 0, 46, 0, 1, 0, 1'h0, 1'h1, 1'h1, 1'h0, 1'h0);
  localparam cit_entry_t E_LONG_UDIV  = citMk(2, 0, 46, 0, 1, 0, 1'h0, 1'h1, 1'h1, 1'h0, 1'h0);
  localparam cit_entry_t E_LONG_SDIV  = citMk(2, 0, 62, 0, 1, 0, 1'h0, 1'h1, 1'h1, 1'h0, 1'h0);
  localparam cit_entry_t E_TBL_MEM    = citMk(6, 0, 33, 2, 1, 0, 1'h1, 1'h1, 1'h1, 1'h0, 1'h0);
  localparam cit_entry_t E_DEC_REG    = citMk(2, 0, 4, 0, 1, 0, 1'h0, 1'h0, 1'h0, 1'h0, 1'h0);
  localparam cit_entry_t E_DEC_MEM    = citMk(2, 2, 12, 2, 1, 1, 1'h0, 1'h0, 1'h0, 1'h0, 1'h0);
  localparam cit_entry_t E_EXT_REG    = citMk(0, 0, 2, 0, 1, 0, 1'h0, 1'h0, 1'h0, 1'h0, 1'h0);
  localparam cit_entry_t E_EXT_MEM    = citMk(2, 2, 10, 2, 1, 1, 1'h0, 1'h0, 1'h0, 1'h0, 1'h0);
  localparam cit_entry_t E_POSTINCREMENT_MEMORY_COMPARE       = citMk(1, 0, 8, 2, 1, 0, 1'h0, 1'h0, 1'h0, 1'h0, 1'h0);
  localparam cit_entry_t E_ALT_RD     = citMk(7, 1, 11, 1, 1, 0, 1'h1, 1'h1, 1'h1, 1'h1, 1'h0);
  localparam cit_entry_t E_ALT_WR     = citMk(9, 2, 12, 0, 1, 1, 1'h1, 1'h1, 1'h1, 1'h1, 1'h0);
  localparam cit_entry_t E_MULTI_RD_W = citMk(1, 0, 8, 1, 2, 0, 1'h0, 1'h0, 1'h1, 1'h1, 1'h1);
  localparam cit_entry_t E_MULTI_RD_L = citMk(1, 0, 12, 2, 2, 0, 1'h0, 1'h0, 1'h1, 1'h1, 1'h1);
  localparam cit_entry_t E_MULTI_WR_W = citMk(1, 0, 8, 0, 2, 0, 1'h0, 1'h0, 1'h1, 1'h1, 1'h1);
  localparam cit_entry_t E_MULTI_WR_L = citMk(1, 2, 10, 0, 2, 0, 1'h0, 1'h0, 1'h1, 1'h1, 1'h1);

endpackage : cit_pkg

/* cit_timing_rom.sv */
`timescale 1ns/1ps
module cit_timing_rom
  import cit_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       arst_n,
  input  wire cit_op_t    op,
  input  wire logic       longSize,
  input  wire logic       signedOp,
  output cit_entry_t      entry
);

  cit_entry_t entryNext;
  cit_entry_t entryReg;

  // Table lookup; the registered output costs one decode cycle but keeps the wide mux off the counter paths.
  // per-class figures.
  always_comb begin
    unique case (op)
      OP_ALU_REG:   entryNext = E_ALU_REG;
      OP_ALU_MEM:   entryNext = E_ALU_MEM;
      OP_IMM_REG:   entryNext = E_IMM_REG;
      OP_IMM_MEM:   entryNext = E_IMM_MEM;
      OP_QUICK_REG: entryNext = E_QUICK_REG;
      OP_QUICK_MEM: entryNext = E_QUICK_MEM;
      OP_WORD_MUL:  entryNext = E_WORD_MUL;
      OP_WORD_DIV:  entryNext = signedOp ? E_WORD_SDIV : E_WORD_UDIV;
      OP_LONG_MUL:  entryNext = E_LONG_MUL;
      OP_LONG_DIV:  entryNext = signedOp ? E_LONG_SDIV : E_LONG_UDIV;
      OP_TBL_MEM:   entryNext = E_TBL_MEM;
      OP_DEC_REG:   entryNext = E_DEC_REG;
      OP_DEC_MEM:   entryNext = E_DEC_MEM;
      OP_EXT_REG:   entryNext = E_EXT_REG;
      OP_EXT_MEM:   entryNext = E_EXT_MEM;
      OP_POSTINCREMENT_MEMORY_COMPARE:      entryNext = E_POSTINCREMENT_MEMORY_COMPARE;
      OP_ALT_RD:    entryNext = E_ALT_RD;
      OP_ALT_WR:    entryNext = E_ALT_WR;
      OP_MULTI_RD:  entryNext = longSize ? E_MULTI_RD_L : E_MULTI_RD_W;
      OP_MULTI_WR:  entryNext = longSize ? E_MULTI_WR_L : E_MULTI_WR_W;
      default:      entryNext = E_ALU_REG; // Unused op codes fall back to a register operation.
    endcase
  end

  // Lookup register.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      entryReg <= E_ALU_REG;
    end else begin
      entryReg <= entryNext;
    end
  end

  assign entry = entryReg;

endmodule : cit_timing_rom

/* cit_timing_core.sv */
`timescale 1ns/1ps
module cit_timing_core
  import cit_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic        reqValid,
  output logic             reqReady,
  input  wire cit_req_t    req,
  output logic             busReq,
  output logic             busWrite,
  output logic             busPrefetch,
  input  wire logic        busAck,
  output logic             busy,
  output logic             done,
  output cit_result_t      result
);

  typedef enum logic [2:0] {ST_IDLE, ST_DECODE, ST_SAVE, ST_EA, ST_OPER} cit_state_t;

  // Long multiply and divide are the only classes whose save step depends on the source.
  function automatic logic isLongMulDiv(input cit_op_t op);
    return (op == OP_LONG_MUL) || (op == OP_LONG_DIV);
  endfunction : isLongMulDiv

  cit_state_t             stateReg,      stateNext;
  cit_req_t               reqReg,        reqNext;
  cit_result_t            resultReg,     resultNext;
  logic [4:0]             prevTailReg,   prevTailNext;
  logic                   b2bReg,        b2bNext;
  logic                   tolReg,        tolNext;
  logic                   doneReg,       doneNext;
  logic [CNT_W-1:0]       phaseCntReg,   phaseCntNext;
  logic [CNT_W-1:0]       opCntReg,      opCntNext;
  logic [CNT_W-1:0]       eaCntReg,      eaCntNext;
  logic [BUS_W-1:0]       readsLeftReg,  readsLeftNext;
  logic [BUS_W-1:0]       prefLeftReg,   prefLeftNext;
  logic [BUS_W-1:0]       writesLeftReg, writesLeftNext;
  logic [3:0]             waitCntReg,    waitCntNext;

  cit_entry_t             entry;
  logic [BUS_W-1:0]       nScaled;
  logic [BUS_W-1:0]       readsCalc;
  logic [BUS_W-1:0]       prefCalc;
  logic [BUS_W-1:0]       writesCalc;
  logic [CNT_W-1:0]       opCalc;
  logic [CNT_W-1:0]       eaCalc;
  logic [CNT_W-1:0]       overlapCalc;
  logic [4:0]             tailCalc;
  logic                   saveCalc;
  logic [BUS_W-1:0]       busTotal;
  logic [3:0]             allow;
  logic                   busLate;
  logic                   lastBus;
  logic                   finishing;
  logic                   stall;
  logic                   accept;

  // The lookup is addressed by the incoming request so its entry is ready in the decode cycle.
  cit_timing_rom u_rom (
    .clk      (clk),
    .arst_n   (arst_n),
    .op       (req.op),
    .longSize (req.longSize),
    .signedOp (req.signedOp),
    .entry    (entry)
  );

  // Scale the base entry by operand size and register count, then take off any overlap.
  always_comb begin
    nScaled    = reqReg.longSize ? BUS_W'({reqReg.regCount, 1'h0}) : BUS_W'(reqReg.regCount);
    readsCalc  = BUS_W'(entry.reads);
    prefCalc   = BUS_W'(entry.prefetch);
    writesCalc = BUS_W'(entry.writes);
    opCalc     = entry.cycles;
    tailCalc   = 5'(entry.tail);
    if (entry.sizeScaled && reqReg.longSize) begin
      readsCalc  = BUS_W'({readsCalc, 1'h0});
      writesCalc = BUS_W'({writesCalc, 1'h0});
      opCalc     = opCalc + LONG_EXTRA;
      tailCalc   = tailCalc + 5'(LONG_EXTRA);
    end
    // Each transferred register adds four clocks and its bus cycles.
    if (entry.perReg) begin
      opCalc = opCalc + CNT_W'({reqReg.regCount, 2'h0});
      if (reqReg.op == OP_MULTI_RD) begin
        readsCalc = readsCalc + nScaled;
      end else begin
        writesCalc = writesCalc + nScaled;
      end
    end
    if (b2bReg) begin
      overlapCalc = (CNT_W'(prevTailReg) < CNT_W'(entry.head)) ? CNT_W'(prevTailReg) : CNT_W'(entry.head);
    end else begin
      overlapCalc = '0;
    end
    opCalc = opCalc - overlapCalc;
    saveCalc = entry.hasSave && !(reqReg.srcIsDreg && isLongMulDiv(reqReg.op));
    eaCalc = entry.addsEa ? CNT_W'(reqReg.eaClocks) : '0;
  end

  // Bus sequencing: reads first, then prefetches, then writes, one access at a time.
  always_comb begin
    busTotal    = readsLeftReg + prefLeftReg + writesLeftReg;
    busReq      = (stateReg == ST_OPER) && (busTotal != '0);
    busWrite    = busReq && (readsLeftReg == '0) && (prefLeftReg == '0);
    busPrefetch = busReq && (readsLeftReg == '0) && (prefLeftReg != '0);
    allow       = tolReg ? BUS_TOLERANT : BUS_NOMINAL;
    busLate     = busReq && !busAck && (waitCntReg >= allow);
    lastBus     = busReq && busAck && (busTotal == BUS_W'(1'h1));
    finishing   = (stateReg == ST_OPER) && (opCntReg == CNT_W'(1'h1)) && ((busTotal == '0) || lastBus);
    // The last operation clock also waits for outstanding bus cycles.
    stall       = busLate || ((opCntReg == CNT_W'(1'h1)) && !finishing);
    reqReady    = (stateReg == ST_IDLE) || finishing;
    accept      = reqValid && reqReady;
  end

  // Phase sequencing, counters and the reported timing.
  always_comb begin
    stateNext      = stateReg;
    reqNext        = reqReg;
    resultNext     = resultReg;
    prevTailNext   = prevTailReg;
    b2bNext        = b2bReg;
    tolNext        = tolReg;
    doneNext       = 1'h0;
    phaseCntNext   = phaseCntReg;
    opCntNext      = opCntReg;
    eaCntNext      = eaCntReg;
    readsLeftNext  = readsLeftReg;
    prefLeftNext   = prefLeftReg;
    writesLeftNext = writesLeftReg;
    waitCntNext    = waitCntReg;
    unique case (stateReg)
      ST_IDLE: begin
      end
      ST_DECODE: begin
        resultNext.totalClocks = (saveCalc ? SAVE_CLOCKS : '0) + eaCalc + opCalc;
        resultNext.head        = entry.head;
        resultNext.tail        = tailCalc;
        resultNext.busCycles   = readsCalc + prefCalc + writesCalc;
        tolNext                = entry.tolerant;
        opCntNext              = opCalc;
        eaCntNext              = eaCalc;
        readsLeftNext          = readsCalc;
        prefLeftNext           = prefCalc;
        writesLeftNext         = writesCalc;
        waitCntNext            = '0;
        if (saveCalc) begin
          stateNext    = ST_SAVE;
          phaseCntNext = SAVE_CLOCKS;
        end else if (eaCalc != '0) begin
          stateNext    = ST_EA;
          phaseCntNext = eaCalc;
        end else begin
          stateNext = ST_OPER;
        end
      end
      ST_SAVE: begin
        if (phaseCntReg == CNT_W'(1'h1)) begin
          stateNext    = (eaCntReg != '0) ? ST_EA : ST_OPER;
          phaseCntNext = eaCntReg;
        end else begin
          phaseCntNext = phaseCntReg - CNT_W'(1'h1);
        end
      end
      ST_EA: begin
        if (phaseCntReg == CNT_W'(1'h1)) begin
          stateNext = ST_OPER;
        end else begin
          phaseCntNext = phaseCntReg - CNT_W'(1'h1);
        end
      end
      ST_OPER: begin
        if (busReq && busAck) begin
          waitCntNext = '0;
          if (readsLeftReg != '0) begin
            readsLeftNext = readsLeftReg - BUS_W'(1'h1);
          end else if (prefLeftReg != '0) begin
            prefLeftNext = prefLeftReg - BUS_W'(1'h1);
          end else begin
            writesLeftNext = writesLeftReg - BUS_W'(1'h1);
          end
        end else if (busReq && (waitCntReg != WAIT_MAX)) begin
          waitCntNext = waitCntReg + 4'h1;
        end
        if (!stall && (opCntReg > CNT_W'(1'h1))) begin
          opCntNext = opCntReg - CNT_W'(1'h1);
        end
        if (finishing) begin
          doneNext  = 1'h1;
          stateNext = ST_IDLE;
        end
      end
    endcase
    if (accept) begin
      reqNext      = req;
      b2bNext      = finishing;
      prevTailNext = resultReg.tail;
      stateNext    = ST_DECODE;
    end
  end

  // State registers.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      stateReg      <= ST_IDLE;
      reqReg        <= '0;
      resultReg     <= '0;
      prevTailReg   <= '0;
      b2bReg        <= 1'h0;
      tolReg        <= 1'h0;
      doneReg       <= 1'h0;
      phaseCntReg   <= '0;
      opCntReg      <= '0;
      eaCntReg      <= '0;
      readsLeftReg  <= '0;
      prefLeftReg   <= '0;
      writesLeftReg <= '0;
      waitCntReg    <= '0;
    end else begin
      stateReg      <= stateNext;
      reqReg        <= reqNext;
      resultReg     <= resultNext;
      prevTailReg   <= prevTailNext;
      b2bReg        <= b2bNext;
      tolReg        <= tolNext;
      doneReg       <= doneNext;
      phaseCntReg   <= phaseCntNext;
      opCntReg      <= opCntNext;
      eaCntReg      <= eaCntNext;
      readsLeftReg  <= readsLeftNext;
      prefLeftReg   <= prefLeftNext;
      writesLeftReg <= writesLeftNext;
      waitCntReg    <= waitCntNext;
    end
  end

  assign busy   = (stateReg != ST_IDLE);
  assign done   = doneReg;
  assign result = resultReg;

  // Checks on the computed timing and on the bus pacing.
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  logic dec;
  assign dec = (stateReg == ST_DECODE) && !b2bReg;

  a_long_bus_pair: assert property (dec && reqReg.op == OP_IMM_MEM |=>
    resultReg.busCycles == (reqReg.longSize ? 6'h03 : 6'h02)) else $error("bus cycle count per size wrong");
  a_long_tail_extra: assert property (dec && reqReg.op == OP_ALU_MEM && reqReg.longSize |=>
    resultReg.tail == 5'h05 && resultReg.totalClocks == 8'h07 + {2'h0, reqReg.eaClocks}) else $error("long extra wrong");
  a_tolerant_no_stall: assert property (stateReg == ST_OPER && tolReg && busReq && !busAck
    && waitCntReg == 4'h2 && opCntReg > 8'h02 |=> opCntReg == $past(opCntReg) - 8'h01) else $error("tolerant stalled");
  a_alt_save_step: assert property ((stateReg == ST_DECODE) && reqReg.op == OP_ALT_RD |=>
    (stateReg == ST_SAVE) [*3] ##1 stateReg != ST_SAVE) else $error("save step length wrong");
  a_skip_save_dreg: assert property ((stateReg == ST_DECODE) && isLongMulDiv(reqReg.op) && reqReg.srcIsDreg |=>
    stateReg != ST_SAVE) else $error("save step not skipped");
  a_mul_sign_same: assert property (dec && reqReg.op == OP_WORD_MUL |=>
    resultReg.totalClocks == 8'h1A + {2'h0, reqReg.eaClocks}) else $error("multiply timing depends on sign");
  a_slow_bus_stall: assert property (stateReg == ST_OPER && !tolReg && busReq && !busAck
    && waitCntReg >= 4'h2 |=> opCntReg == $past(opCntReg)) else $error("slow answer did not stretch");
  a_word_divide: assert property (dec && reqReg.op == OP_WORD_DIV |=>
    resultReg.totalClocks == (reqReg.signedOp ? 8'h2A : 8'h20) + {2'h0, reqReg.eaClocks}) else $error("word divide");
  a_long_divide_max: assert property (dec && reqReg.op == OP_LONG_DIV && reqReg.srcIsDreg |=>
    resultReg.totalClocks <= (reqReg.signedOp ? 8'h3E : 8'h2E) + {2'h0, reqReg.eaClocks}) else $error("long divide");
  a_immediate_fetch: assert property (dec && reqReg.op == OP_IMM_REG |=>
    resultReg.totalClocks == 8'h02 + {2'h0, reqReg.eaClocks}) else $error("immediate fetch not added");
  a_quick_no_fetch: assert property (dec && reqReg.op == OP_QUICK_MEM && !reqReg.longSize |=>
    resultReg.totalClocks == 8'h05) else $error("quick form timing wrong");
  a_mem_writeback: assert property (dec && (reqReg.op == OP_ALU_MEM || reqReg.op == OP_IMM_MEM
    || reqReg.op == OP_QUICK_MEM) && !reqReg.longSize |=>
    resultReg.tail == 5'h03 && resultReg.busCycles == 6'h02) else $error("writeback tail wrong");
  a_decimal_memory: assert property (dec && (reqReg.op == OP_DEC_MEM || reqReg.op == OP_EXT_MEM) |=>
    resultReg.totalClocks == ($past(reqReg.op) == OP_DEC_MEM ? 8'h0C : 8'h0A)) else $error("decimal timing wrong");
  a_compare_memory: assert property (dec && reqReg.op == OP_POSTINCREMENT_MEMORY_COMPARE |=>
    resultReg.totalClocks == 8'h08 && resultReg.busCycles == 6'h03) else $error("memory compare timing wrong");
  a_overlap_accept: assert property (finishing && reqValid |=>
    stateReg == ST_DECODE && b2bReg && doneReg) else $error("back-to-back request not overlapped");

endmodule : cit_timing_core

/* cit_mem_model.sv */
`timescale 1ns/1ps
module cit_mem_model
  import cit_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       arst_n,
  input  wire logic       busReq,
  input  wire logic [3:0] waitClocks,
  output logic            busAck
);
  logic [3:0] cntReg;
  logic [3:0] cntNext;
  logic       ackReg;
  logic       ackNext;

  // access stretch.
  // Zero extra wait gives the nominal two-clock access; larger values model slow memory.
  always_comb begin
    cntNext = cntReg + 4'h1;
    ackNext = 1'h0;
    if (!busReq || ackReg) begin
      cntNext = 4'h0;
    end else if (cntReg == waitClocks) begin
      cntNext = cntReg;
      ackNext = 1'h1;
    end
  end

  // The acknowledge is registered, so it never answers in the cycle the request rises.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cntReg <= 4'h0;
      ackReg <= 1'h0;
    end else begin
      cntReg <= cntNext;
      ackReg <= ackNext;
    end
  end

  assign busAck = ackReg;
endmodule : cit_mem_model

/* tb_top.sv */
`timescale 1ns/1ps
module tb_top
  import cit_pkg::*;
;
  logic        clk = 1'b0;
  logic        arst_n = 1'b0;
  logic        reqValid = 1'b0;
  cit_req_t    req = '0;
  logic [3:0]  waitClocks = 4'h0;
  logic [4:0]  nRegs = 5'h00;
  logic        reqReady, busReq, busWrite, busPrefetch, busAck, busy, done;
  cit_result_t result;
  int          miscompares = 0;
  int          n_checks = 0;
  int          latA, latB;

  cit_timing_core i_cit_timing_core (.clk(clk), .arst_n(arst_n), .reqValid(reqValid), .reqReady(reqReady),
    .req(req), .busReq(busReq), .busWrite(busWrite), .busPrefetch(busPrefetch), .busAck(busAck),
    .busy(busy), .done(done), .result(result));
  cit_mem_model i_cit_mem_model (.clk(clk), .arst_n(arst_n), .busReq(busReq), .waitClocks(waitClocks),
    .busAck(busAck));

  // Half period of 4 ns gives the 125 MHz clock.
  always #4 clk = ~clk;

  task complete_run;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : complete_run

  task chk(input string name, input logic [7:0] expv, input logic [7:0] got);
    n_checks++;
    if (got !== expv) begin
      miscompares++;
      $display("MISMATCH %s expected %0d seen %0d", name, expv, got);
    end
  endtask : chk

  // Issues one instruction while idle, counts completed accesses and clocks until done.
  task do_op(input cit_op_t op, input logic lng, input logic sgn, input logic dreg, input logic [5:0] ea,
             input logic [7:0] expTot, input logic [7:0] expBus, output int lat);
    int i;
    int nb;
    @(posedge clk);
    reqValid <= 1'b1;
    req      <= '{op: op, longSize: lng, signedOp: sgn, srcIsDreg: dreg, eaClocks: ea, regCount: nRegs};
    @(posedge clk);
    reqValid <= 1'b0;
    lat = 0;
    nb  = 0;
    for (i = 0; i < 400 && done !== 1'b1; i++) begin
      @(posedge clk);
      lat++;
      if (busReq === 1'b1 && busAck === 1'b1) nb++;
    end
    if (i == 400) begin
      miscompares++;
      $display("MISMATCH done expected 1 seen 0");
      complete_run();
    end
    chk("totalClocks", expTot, result.totalClocks);
    chk("busCycles", expBus, {2'h0, result.busCycles});
    chk("accessCount", expBus, 8'(nb));
  endtask : do_op

  // Quick forms ignore the address time; long memory writes add a bus cycle and two clocks.
  task sc_quick;
    do_op(OP_QUICK_REG, 1'b0, 1'b0, 1'b0, 6'h05, 8'h02, 8'h01, latA);
    do_op(OP_QUICK_MEM, 1'b0, 1'b0, 1'b0, 6'h00, 8'h05, 8'h02, latA);
    do_op(OP_QUICK_MEM, 1'b1, 1'b0, 1'b0, 6'h00, 8'h07, 8'h03, latA);
  endtask : sc_quick

  // Immediate forms add the fetch time of the immediate operand.
  task sc_imm;
    do_op(OP_IMM_REG, 1'b0, 1'b0, 1'b0, 6'h04, 8'h06, 8'h01, latA);
    do_op(OP_IMM_MEM, 1'b0, 1'b0, 1'b0, 6'h04, 8'h09, 8'h02, latA);
    do_op(OP_ALU_MEM, 1'b1, 1'b0, 1'b0, 6'h00, 8'h07, 8'h03, latA);
    do_op(OP_ALU_REG, 1'b0, 1'b0, 1'b0, 6'h03, 8'h05, 8'h01, latA);
  endtask : sc_imm

  // Signedness must not change multiply time; divides differ and the save step depends on source.
  task sc_muldiv;
    do_op(OP_WORD_MUL, 1'b0, 1'b0, 1'b0, 6'h00, 8'h1A, 8'h01, latA);
    do_op(OP_WORD_MUL, 1'b0, 1'b1, 1'b0, 6'h00, 8'h1A, 8'h01, latA);
    do_op(OP_WORD_DIV, 1'b0, 1'b0, 1'b0, 6'h00, 8'h20, 8'h01, latA);
    do_op(OP_WORD_DIV, 1'b0, 1'b1, 1'b0, 6'h00, 8'h2A, 8'h01, latA);
    do_op(OP_LONG_DIV, 1'b0, 1'b0, 1'b1, 6'h00, 8'h2E, 8'h01, latA);
    do_op(OP_LONG_DIV, 1'b0, 1'b1, 1'b0, 6'h00, 8'h41, 8'h01, latA);
    do_op(OP_LONG_MUL, 1'b0, 1'b1, 1'b1, 6'h00, 8'h2E, 8'h01, latA);
    do_op(OP_TBL_MEM, 1'b0, 1'b0, 1'b0, 6'h00, 8'h24, 8'h03, latA);
    do_op(OP_TBL_MEM, 1'b0, 1'b1, 1'b0, 6'h00, 8'h24, 8'h03, latA);
  endtask : sc_muldiv

  // Decimal, extended and compare forms are self-contained.
  task sc_bcd;
    do_op(OP_DEC_REG, 1'b0, 1'b0, 1'b0, 6'h03, 8'h04, 8'h01, latA);
    do_op(OP_EXT_REG, 1'b0, 1'b0, 1'b0, 6'h03, 8'h02, 8'h01, latA);
    do_op(OP_DEC_MEM, 1'b0, 1'b0, 1'b0, 6'h03, 8'h0C, 8'h04, latA);
    do_op(OP_EXT_MEM, 1'b0, 1'b0, 1'b0, 6'h00, 8'h0A, 8'h04, latA);
    do_op(OP_POSTINCREMENT_MEMORY_COMPARE, 1'b0, 1'b0, 1'b0, 6'h00, 8'h08, 8'h03, latA);
  endtask : sc_bcd

  // A four-clock access must not slow the alternate-space move.
  task sc_alt;
    waitClocks <= 4'h0;
    do_op(OP_ALT_RD, 1'b0, 1'b0, 1'b0, 6'h02, 8'h10, 8'h02, latA);
    waitClocks <= 4'h2;
    do_op(OP_ALT_RD, 1'b0, 1'b0, 1'b0, 6'h02, 8'h10, 8'h02, latB);
    chk("tolerantLatency", 8'(latA), 8'(latB));
  endtask : sc_alt

  // Register lists add four clocks and their bus cycles per register; alternate-space writes save first.
  task sc_multi;
    nRegs = 5'h03;
    do_op(OP_MULTI_RD, 1'b0, 1'b0, 1'b0, 6'h00, 8'h14, 8'h06, latA);
    nRegs = 5'h02;
    do_op(OP_MULTI_RD, 1'b1, 1'b0, 1'b0, 6'h00, 8'h14, 8'h08, latA);
    do_op(OP_MULTI_WR, 1'b1, 1'b0, 1'b0, 6'h00, 8'h12, 8'h06, latA);
    nRegs = 5'h00;
    do_op(OP_ALT_WR, 1'b0, 1'b0, 1'b0, 6'h02, 8'h11, 8'h02, latA);
    do_op(OP_ALT_WR, 1'b1, 1'b0, 1'b0, 6'h02, 8'h13, 8'h03, latA);
  endtask : sc_multi

  // A decimal memory op queued behind a long memory write hides its two-clock head under that write's tail.
  task sc_b2b;
    int i;
    int j;
    @(posedge clk);
    reqValid <= 1'b1;
    req      <= '{op: OP_ALU_MEM, longSize: 1'b1, signedOp: 1'b0, srcIsDreg: 1'b0, eaClocks: 6'h00, regCount: 5'h00};
    @(posedge clk);
    req      <= '{op: OP_DEC_MEM, longSize: 1'b0, signedOp: 1'b0, srcIsDreg: 1'b0, eaClocks: 6'h00, regCount: 5'h00};
    @(posedge clk);
    for (i = 0; i < 400 && reqReady !== 1'b1; i++) @(posedge clk);
    reqValid <= 1'b0;
    @(posedge clk);
    chk("overlapDone", 8'h01, {7'h00, done});
    @(posedge clk);
    for (j = i; j < 400 && done !== 1'b1; j++) @(posedge clk);
    if (j >= 400) begin
      miscompares++;
      $display("MISMATCH overlapDone expected 1 seen 0");
      complete_run();
    end
    chk("overlapTotal", 8'h0A, result.totalClocks);
    chk("overlapBus", 8'h04, {2'h0, result.busCycles});
  endtask : sc_b2b

  // Slow memory on a non-tolerant operation must lengthen execution.
  task sc_slow;
    waitClocks <= 4'h0;
    do_op(OP_QUICK_MEM, 1'b0, 1'b0, 1'b0, 6'h00, 8'h05, 8'h02, latA);
    waitClocks <= 4'h3;
    do_op(OP_QUICK_MEM, 1'b0, 1'b0, 1'b0, 6'h00, 8'h05, 8'h02, latB);
    chk("slowLonger", 8'h01, 8'(latB > latA));
    waitClocks <= 4'h0;
  endtask : sc_slow

  // Main sequence after three reset cycles.
  initial begin
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    sc_quick();
    sc_imm();
    sc_muldiv();
    sc_bcd();
    sc_alt();
    sc_slow();
    sc_multi();
    sc_b2b();
    complete_run();
  end
endmodule : tb_top
